/* rtl/coil_pkg.sv */
// coil evaluation constants: modes, relay groups, reset values
// assumes a scan-cycle controller that strobes once per finished program pass
package coil_pkg;
    typedef enum logic [2:0] {
        MODE_CONTACTOR = 3'h0,
        MODE_INVERSE   = 3'h1,
        MODE_FALL_PLS  = 3'h2,
        MODE_RISE_PLS  = 3'h3,
        MODE_IMPULSE   = 3'h4,
        MODE_LATCH     = 3'h5,
        MODE_UNLATCH   = 3'h6
    } coil_mode_t;

    typedef enum logic [2:0] {
        GRP_OUTPUT = 3'h0,
        GRP_MARKER = 3'h1,
        GRP_FLAG2  = 3'h2,
        GRP_TEXT   = 3'h3,
        GRP_EXPAN  = 3'h4,
        GRP_JUMP   = 3'h5
    } relay_grp_t;

    localparam int  DEF_RELAYS    = 8;
    localparam int  DEF_SLOT_W    = 4;
    localparam logic STATE_RST    = 1'b0;
    localparam logic HIST_RST     = 1'b0;
endpackage

/* rtl/relay_coil_unit.sv */
// relay coil evaluation: one coil write per clock, relay state resolved per scan
// assumes the rung evaluator streams coil writes in program order, then strobes scan_done_i
`timescale 1ns/1ps
`default_nettype none

module relay_coil_unit #(
    parameter int RELAYS = coil_pkg::DEF_RELAYS,
    parameter int SLOT_W = coil_pkg::DEF_SLOT_W
) (
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    input  wire logic                    ce_i,
    input  wire logic                    power_fail_i,
    input  wire logic                    stop_i,
    input  wire logic                    coil_we_i,
    input  wire logic [SLOT_W-1:0]       coil_sel_i,
    input  wire coil_pkg::coil_mode_t    coil_mode_i,
    input  wire logic                    coil_val_i,
    input  wire logic                    scan_done_i,
    input  wire coil_pkg::relay_grp_t    relay_grp_i [RELAYS],
    input  wire logic [RELAYS-1:0]       retain_i,
    output logic      [RELAYS-1:0]       contact_o,
    output logic      [RELAYS-1:0]       func_start_o,
    output logic                         mode_err_o
);
    import coil_pkg::*;

    generate
        if (RELAYS < 1 || RELAYS > (1 << SLOT_W)) begin : g_bad_cfg
            $error("relay count does not fit the select width");
        end
    endgenerate

    function automatic logic edge_ok(input relay_grp_t g);
        edge_ok = (g == GRP_MARKER) || (g == GRP_FLAG2) || (g == GRP_JUMP);
    endfunction

    // pending per-scan writes, resolved at scan_done_i
    logic [RELAYS-1:0] pend_wr;
    logic [RELAYS-1:0] pend_val;
    logic [RELAYS-1:0] pend_set;
    logic [RELAYS-1:0] pend_clr;
    coil_mode_t        pend_mode [RELAYS];
    logic [RELAYS-1:0] hist;
    logic [RELAYS-1:0] state;
    logic [RELAYS-1:0] fstart;
    logic              err;
    logic [RELAYS-1:0] refuse_hit;

    wire clear_all = power_fail_i | stop_i;
    wire is_edge   = (coil_mode_i == MODE_FALL_PLS) || (coil_mode_i == MODE_RISE_PLS);

    genvar gi;
    generate
        for (gi = 0; gi < RELAYS; gi++) begin : g_relay
            wire hit      = coil_we_i && (coil_sel_i == SLOT_W'(gi));
            wire refused  = is_edge && !edge_ok(relay_grp_i[gi]);
            wire is_latch = coil_mode_i == MODE_LATCH;
            wire is_unl   = coil_mode_i == MODE_UNLATCH;
            wire acc      = hit && !refused;
            wire take_val = acc && !is_latch && !is_unl;
            wire in_now   = pend_val[gi];
            wire rise     = in_now && !hist[gi];
            wire fall     = !in_now && hist[gi];
            logic next_state;

            assign refuse_hit[gi] = hit && refused;

            always_comb begin
                next_state = state[gi];
                if (pend_wr[gi]) begin
                    unique case (pend_mode[gi])
                        MODE_CONTACTOR: next_state = in_now;
                        MODE_INVERSE:   next_state = !in_now;
                        MODE_FALL_PLS:  next_state = fall;
                        MODE_RISE_PLS:  next_state = rise;
                        MODE_IMPULSE:   next_state = state[gi] ^ rise;
                        default:        next_state = state[gi];
                    endcase
                end
                if (pend_set[gi])
                    next_state = 1'b1;
                if (pend_clr[gi])
                    next_state = 1'b0;
            end

            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    pend_wr[gi]   <= 1'b0;
                    pend_val[gi]  <= 1'b0;
                    pend_set[gi]  <= 1'b0;
                    pend_clr[gi]  <= 1'b0;
                    pend_mode[gi] <= MODE_CONTACTOR;
                    hist[gi]      <= HIST_RST;
                    state[gi]     <= STATE_RST;
                    fstart[gi]    <= 1'b0;
                end else if (ce_i) begin
                    if (clear_all) begin
                        if (!retain_i[gi]) begin
                            state[gi]  <= 1'b0;
                            fstart[gi] <= 1'b0;
                        end
                        hist[gi]     <= HIST_RST;
                        pend_wr[gi]  <= 1'b0;
                        pend_set[gi] <= 1'b0;
                        pend_clr[gi] <= 1'b0;
                    end else if (scan_done_i) begin
                        state[gi]    <= next_state;
                        fstart[gi]   <= next_state;
                        if (pend_wr[gi])
                            hist[gi] <= pend_val[gi];
                        pend_wr[gi]  <= 1'b0;
                        pend_set[gi] <= 1'b0;
                        pend_clr[gi] <= 1'b0;
                    end else begin
                        // last write in program order wins
                        if (take_val) begin
                            pend_wr[gi]   <= 1'b1;
                            pend_val[gi]  <= coil_val_i;
                            pend_mode[gi] <= coil_mode_i;
                        end
                        // later latch or unlatch overrides earlier
                        if (acc && is_latch && coil_val_i) begin
                            pend_set[gi] <= 1'b1;
                            pend_clr[gi] <= 1'b0;
                        end
                        if (acc && is_unl && coil_val_i) begin
                            pend_clr[gi] <= 1'b1;
                            pend_set[gi] <= 1'b0;
                        end
                    end
                end
            end

            chk_fall_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                ce_i && !clear_all && scan_done_i && pend_wr[gi]
                && pend_mode[gi] == MODE_FALL_PLS && !pend_set[gi] && !pend_clr[gi]
                |=> state[gi] == ($past(hist[gi]) && !$past(pend_val[gi])))
                else $error("falling pulse wrong");
            chk_rise_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                ce_i && !clear_all && scan_done_i && pend_wr[gi]
                && pend_mode[gi] == MODE_RISE_PLS && !pend_set[gi] && !pend_clr[gi]
                |=> state[gi] == (!$past(hist[gi]) && $past(pend_val[gi])))
                else $error("rising pulse wrong");
            chk_impulse_tog: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                ce_i && !clear_all && scan_done_i && pend_wr[gi]
                && pend_mode[gi] == MODE_IMPULSE && !pend_set[gi] && !pend_clr[gi]
                |=> state[gi]
                    == ($past(state[gi]) ^ ($past(pend_val[gi]) && !$past(hist[gi]))))
                else $error("impulse toggle wrong");
            chk_stop_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                ce_i && clear_all && !retain_i[gi] |=> !state[gi])
                else $error("non-retentive coil not cleared");
            chk_retain_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                ce_i && clear_all && retain_i[gi] |=> $stable(state[gi]))
                else $error("retentive coil lost state");
            chk_latch_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                ce_i && !clear_all && scan_done_i && pend_set[gi] |=> state[gi])
                else $error("latch did not set");
            chk_unlatch_win: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                ce_i && !clear_all && !scan_done_i && acc && is_unl && coil_val_i
                |=> pend_clr[gi] && !pend_set[gi])
                else $error("later unlatch did not win");
            chk_hist_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                ce_i && clear_all |=> !hist[gi])
                else $error("edge history kept");
        end
    endgenerate

    // refuse edge modes on output, text or expansion relays
    wire edge_refused = |refuse_hit;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            err <= 1'b0;
        else if (ce_i)
            err <= edge_refused;
    end

    chk_edge_refuse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && edge_refused |=> mode_err_o)
        else $error("refused edge mode not flagged");

    chk_ce_freeze: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !ce_i |=> $stable(contact_o) && $stable(mode_err_o) && $stable(func_start_o))
        else $error("state moved while enable low");

    assign contact_o    = state;
    // function relay start from final coil state
    assign func_start_o = fstart;
    assign mode_err_o   = err;
endmodule

`default_nettype wire

/* verif/rung_model.sv */
// rung evaluator model: coil writes in program order, then a scan end
// assumes the coil unit samples its inputs on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module rung_model (
    input  wire logic           clk_i,
    output logic                coil_we_o,
    output logic [3:0]          coil_sel_o,
    output var coil_pkg::coil_mode_t coil_mode_o,
    output logic                coil_val_o,
    output logic                scan_done_o
);
    import coil_pkg::*;
    initial begin
        coil_we_o   = 1'b0;
        coil_sel_o  = 4'h0;
        coil_mode_o = MODE_CONTACTOR;
        coil_val_o  = 1'b0;
        scan_done_o = 1'b0;
    end
    task automatic write_coil(input logic [3:0] sel, input coil_mode_t mode, input logic val);
        @(negedge clk_i);
        coil_we_o   = 1'b1;
        coil_sel_o  = sel;
        coil_mode_o = mode;
        coil_val_o  = val;
        @(negedge clk_i);
        coil_we_o   = 1'b0;
        coil_sel_o  = ~sel;
        coil_val_o  = ~val;
    endtask
    // scan end strobe, then one cycle for the answer
    task automatic end_scan;
        @(negedge clk_i);
        scan_done_o = 1'b1;
        @(negedge clk_i);
        scan_done_o = 1'b0;
        @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

/* verif/relay_coil_function_unit_tb.sv */
// testbench of the relay coil unit, one task per scenario
// assumes the rung model drives coil writes; bench drives clears
`timescale 1ns/1ps
`default_nettype none
module relay_coil_function_unit_tb;
    import coil_pkg::*;
    logic       clk_i, sys_rst_i, ce, power_fail_i, stop_i, we, val, done, mode_err_o;
    logic [3:0] sel;
    coil_mode_t mode;
    relay_grp_t grp [8];
    logic [7:0] retain, contact_o, func_start_o;
    int         err_total, checks_done, cycles;
    rung_model i_rung (.clk_i(clk_i), .coil_we_o(we), .coil_sel_o(sel), .coil_mode_o(mode),
        .coil_val_o(val), .scan_done_o(done));
    relay_coil_unit i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .power_fail_i(power_fail_i), .stop_i(stop_i), .coil_we_i(we), .coil_sel_i(sel),
        .coil_mode_i(mode), .coil_val_i(val), .scan_done_i(done), .relay_grp_i(grp),
        .retain_i(retain), .contact_o(contact_o), .func_start_o(func_start_o),
        .mode_err_o(mode_err_o));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic check(input logic seen, input logic exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("mismatches %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_contactor;
        i_rung.write_coil(4'h0, MODE_CONTACTOR, 1'b0);
        i_rung.write_coil(4'h0, MODE_CONTACTOR, 1'b1);
        i_rung.write_coil(4'h1, MODE_INVERSE, 1'b1);
        i_rung.end_scan();
        check(contact_o[0], 1'b1);
        check(contact_o[1], 1'b0);
        check(func_start_o[0], 1'b1);
        i_rung.write_coil(4'h1, MODE_INVERSE, 1'b0);
        i_rung.end_scan();
        check(contact_o[1], 1'b1);
    endtask
    task automatic t_pulses;
        i_rung.write_coil(4'h2, MODE_RISE_PLS, 1'b1);
        i_rung.write_coil(4'h3, MODE_FALL_PLS, 1'b1);
        i_rung.end_scan();
        check(contact_o[2], 1'b1);
        check(contact_o[3], 1'b0);
        i_rung.write_coil(4'h2, MODE_RISE_PLS, 1'b1);
        i_rung.write_coil(4'h3, MODE_FALL_PLS, 1'b0);
        i_rung.end_scan();
        check(contact_o[2], 1'b0);
        check(contact_o[3], 1'b1);
        i_rung.write_coil(4'h3, MODE_FALL_PLS, 1'b0);
        i_rung.end_scan();
        check(contact_o[3], 1'b0);
    endtask
    task automatic t_impulse;
        logic [3:0] ins, exp;
        ins = 4'hd;
        exp = 4'h3;
        for (int i = 0; i < 4; i++) begin
            i_rung.write_coil(4'h4, MODE_IMPULSE, ins[i]);
            i_rung.end_scan();
            check(contact_o[4], exp[i]);
        end
    endtask
    task automatic t_latch;
        i_rung.write_coil(4'h5, MODE_LATCH, 1'b1);
        i_rung.end_scan();
        i_rung.end_scan();
        check(contact_o[5], 1'b1);
        i_rung.write_coil(4'h5, MODE_LATCH, 1'b1);
        i_rung.write_coil(4'h5, MODE_UNLATCH, 1'b1);
        i_rung.end_scan();
        check(contact_o[5], 1'b0);
        i_rung.write_coil(4'h5, MODE_UNLATCH, 1'b1);
        i_rung.write_coil(4'h5, MODE_LATCH, 1'b1);
        i_rung.end_scan();
        check(contact_o[5], 1'b1);
    endtask
    task automatic t_refuse;
        i_rung.write_coil(4'h0, MODE_RISE_PLS, 1'b0);
        check(mode_err_o, 1'b1);
        @(negedge clk_i);
        check(mode_err_o, 1'b0);
        i_rung.write_coil(4'h6, MODE_FALL_PLS, 1'b1);
        check(mode_err_o, 1'b1);
        i_rung.write_coil(4'h7, MODE_RISE_PLS, 1'b0);
        check(mode_err_o, 1'b0);
        i_rung.end_scan();
        check(contact_o[0], 1'b1);
    endtask
    task automatic t_freeze;
        i_rung.write_coil(4'h0, MODE_CONTACTOR, 1'b0);
        ce = 1'b0;
        i_rung.end_scan();
        check(contact_o[0], 1'b1);
        ce = 1'b1;
        i_rung.end_scan();
        check(contact_o[0], 1'b0);
        i_rung.write_coil(4'h0, MODE_CONTACTOR, 1'b1);
        i_rung.end_scan();
        check(contact_o[0], 1'b1);
    endtask
    task automatic t_clear;
        i_rung.write_coil(4'h7, MODE_LATCH, 1'b1);
        i_rung.write_coil(4'h3, MODE_FALL_PLS, 1'b1);
        i_rung.end_scan();
        check(contact_o[7], 1'b1);
        stop_i = 1'b1;
        @(negedge clk_i);
        stop_i = 1'b0;
        @(negedge clk_i);
        check(contact_o[0], 1'b0);
        check(contact_o[1], 1'b0);
        check(contact_o[5], 1'b1);
        check(contact_o[7], 1'b0);
        check(func_start_o[0], 1'b0);
        i_rung.write_coil(4'h3, MODE_FALL_PLS, 1'b0);
        i_rung.write_coil(4'h0, MODE_CONTACTOR, 1'b1);
        i_rung.end_scan();
        check(contact_o[3], 1'b0);
        check(contact_o[0], 1'b1);
        power_fail_i = 1'b1;
        @(negedge clk_i);
        power_fail_i = 1'b0;
        @(negedge clk_i);
        check(contact_o[0], 1'b0);
        check(contact_o[5], 1'b1);
    endtask
    initial begin
        sys_rst_i = 1'b1;
        ce = 1'b1;
        power_fail_i = 1'b0;
        stop_i = 1'b0;
        retain = 8'h20;
        grp = '{GRP_OUTPUT, GRP_TEXT, GRP_MARKER, GRP_FLAG2, GRP_MARKER, GRP_OUTPUT,
            GRP_EXPAN, GRP_JUMP};
        err_total = 0;
        checks_done = 0;
        cycles = 0;
        repeat (6) @(negedge clk_i);
        sys_rst_i = 1'b0;
        t_contactor();
        t_pulses();
        t_impulse();
        t_latch();
        t_refuse();
        t_freeze();
        t_clear();
        stop_test();
    end
endmodule
`default_nettype wire
